// >>> sfpi_core.sv
// Pin-level serial flash interface: select, lanes, pause, reset pin
//
// Contract
// R1 - Deselected: all data lanes float
// R2 - Selected: accept input, return read data
// R3 - Host needs select fall after power-up
// R4 - Single lane: capture serial_in on rising clock
// R5 - Single lane: launch serial_out on falling clock
// R6 - Multi lane: capture rising, launch falling
// R7 - Quad only when quad_enable_bit set
// R8 - Quad enable turns protect/pause into lanes
// R9 - Single/dual use lanes 0-1; quad all
// R10 - Pause works only outside quad operation
// R11 - Reset pin resets regardless of state
// R12 - Pause while selected: float, ignore inputs
// R13 - Reset pulse of 1 us aborts all
// R14 - Host uses clock mode 0 or 3
// R15 - Host releases lanes during read phases
`timescale 1ns/1ps
module sfpi_core
    import sfpi_pkg::*;
(
    input  wire logic          sys_clk_in,
    input  wire logic          reset_n_in,
    input  wire logic          chip_select_n_in,
    input  wire logic          serial_clock_in,
    input  wire logic          hardware_reset_n_in,
    input  wire logic          data_lane_0_in,
    output logic               data_lane_0_out,
    output logic               data_lane_0_oe_out,
    input  wire logic          data_lane_1_in,
    output logic               data_lane_1_out,
    output logic               data_lane_1_oe_out,
    input  wire logic          data_lane_2_in,
    output logic               data_lane_2_out,
    output logic               data_lane_2_oe_out,
    input  wire logic          data_lane_3_in,
    output logic               data_lane_3_out,
    output logic               data_lane_3_oe_out,
    input  wire logic          quad_enable_bit_in,
    input  wire sfpi_mode_type lane_mode_in,
    input  wire logic          drive_in,
    input  wire logic          tx_valid_in,
    output logic               tx_ready_out,
    input  wire logic [7:0]    tx_data_in,
    output logic               rx_valid_out,
    input  wire logic          rx_ready_in,
    output logic      [7:0]    rx_data_out,
    output logic               rx_overrun_out,
    output logic               selected_out,
    output logic               paused_out,
    output logic               write_protect_n_out,
    output logic               device_reset_out
);

    // ----------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ----------------------------------------------------------------
    logic [SYNC_WIDTH-1:0] pins_sync;
    logic                  cs_s;
    logic                  sclk_s;
    logic                  hwrst_s;
    logic [3:0]            lanes_s;
    logic                  sclk_q_reg;
    logic                  clk_rise;
    logic                  clk_fall;

    sfpi_sync #(
        .WIDTH (SYNC_WIDTH)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .reset_n_in (reset_n_in),
        .async_in   ({hardware_reset_n_in, data_lane_3_in, data_lane_2_in,
                      data_lane_1_in, data_lane_0_in, serial_clock_in,
                      chip_select_n_in}),
        .sync_out   (pins_sync)
    );

    assign cs_s    = pins_sync[0];
    assign sclk_s  = pins_sync[1];
    assign lanes_s = pins_sync[5:2];
    assign hwrst_s = pins_sync[6];

    // Edges are taken from synchronised levels only; mode 0 and 3 alike
    assign clk_rise = sclk_s && !sclk_q_reg;   // R14
    assign clk_fall = !sclk_s && sclk_q_reg;

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            sclk_q_reg <= 1'h0;
        else
            sclk_q_reg <= sclk_s;
    end

    // ----------------------------------------------------------------
    // Mode resolution and pin reuse
    // ----------------------------------------------------------------
    sfpi_mode_type eff_mode;
    logic          pause_low;
    logic [2:0]    last_cnt;
    logic [3:0]    lane_use;

    // Quad request without the enable bit falls back to one lane
    always_comb
    begin
        eff_mode = lane_mode_in;
        if (lane_mode_in == MODE_QUAD && !quad_enable_bit_in)   // R7
            eff_mode = MODE_SINGLE;
    end

    // Lane count sets bits per clock and which pins are driven
    always_comb
    begin
        unique case (eff_mode)
            MODE_DUAL:
            begin
                last_cnt = LAST_CNT_DUAL;
                lane_use = LANES_DUAL;                           // R9
            end
            MODE_QUAD:
            begin
                last_cnt = LAST_CNT_QUAD;
                lane_use = LANES_QUAD;                           // R9
            end
            default:
            begin
                last_cnt = LAST_CNT_SINGLE;
                lane_use = LANES_SINGLE;                         // R9
            end
        endcase
    end

    // With quad enabled the pause pin is a data lane, never a pause
    assign pause_low = !quad_enable_bit_in && !lanes_s[3];      // R10 R8

    // Protect level only means something while lane 2 is not data
    assign write_protect_n_out = quad_enable_bit_in ? 1'h1 : lanes_s[2]; // R8

    // ----------------------------------------------------------------
    // Hardware reset pin filter
    // ----------------------------------------------------------------
    logic [3:0] hw_cnt_reg;
    logic [3:0] hw_cnt_next;
    logic       hw_hold;

    // Short glitches do nothing; a full pulse holds the abort
    assign hw_hold = (hw_cnt_reg == RESET_CNT_MAX);              // R13

    always_comb
    begin
        hw_cnt_next = hw_cnt_reg;
        if (hwrst_s)
            hw_cnt_next = RESET_CNT_INIT;
        else if (!hw_hold)
            hw_cnt_next = hw_cnt_reg + 4'h1;
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            hw_cnt_reg <= RESET_CNT_INIT;
        else
            hw_cnt_reg <= hw_cnt_next;
    end

    assign device_reset_out = hw_hold;

    // ----------------------------------------------------------------
    // Select state
    // ----------------------------------------------------------------
    sfpi_state_type state_reg;
    sfpi_state_type state_next;

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_WAIT_HIGH:
                if (cs_s)                                        // R3
                    state_next = ST_DESELECTED;
            ST_DESELECTED:
                if (!cs_s)                                       // R2
                    state_next = ST_ACTIVE;
            ST_ACTIVE:
                if (cs_s)
                    state_next = ST_DESELECTED;
                else if (pause_low)                              // R12
                    state_next = ST_PAUSED;
            ST_PAUSED:
                if (cs_s)
                    state_next = ST_DESELECTED;
                else if (!pause_low)                             // R12
                    state_next = ST_ACTIVE;
        endcase
        // Reset pin overrides every state and setting
        if (hw_hold)                                             // R11
            state_next = ST_WAIT_HIGH;
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            state_reg <= ST_WAIT_HIGH;
        else
            state_reg <= state_next;
    end

    assign selected_out = (state_reg == ST_ACTIVE) ||
                          (state_reg == ST_PAUSED);
    assign paused_out   = (state_reg == ST_PAUSED);

    // ----------------------------------------------------------------
    // Shift engine
    // ----------------------------------------------------------------
    logic       run;
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic [7:0] rx_sh_reg;
    logic [7:0] rx_sh_next;
    logic [7:0] tx_sh_reg;
    logic [7:0] tx_sh_next;
    logic [3:0] out_reg;
    logic [3:0] out_next;
    logic       push_reg;
    logic       push_next;
    logic [7:0] tx_src;
    logic       tx_take;
    logic       tx_full_reg;
    logic       tx_full_next;
    logic [7:0] tx_hold_reg;
    logic [7:0] tx_hold_next;
    logic       fifo_in_ready;

    assign run = (state_reg == ST_ACTIVE) && !cs_s && !pause_low && !hw_hold;
    // Underrun sends the idle byte rather than stalling the host clock
    assign tx_src = (cnt_reg != CNT_INIT) ? tx_sh_reg :
                    (tx_full_reg ? tx_hold_reg : TX_IDLE_BYTE);
    assign tx_take = run && drive_in && clk_fall &&
                     (cnt_reg == CNT_INIT) && tx_full_reg;

    // Capture on rise, launch on fall; a deselect drops any part byte
    always_comb
    begin
        cnt_next   = cnt_reg;
        rx_sh_next = rx_sh_reg;
        tx_sh_next = tx_sh_reg;
        out_next   = out_reg;
        push_next  = 1'h0;
        if (hw_hold || cs_s)
            cnt_next = CNT_INIT;
        else if (run && !drive_in && clk_rise)                   // R4 R6
        begin
            unique case (eff_mode)
                MODE_DUAL:
                    rx_sh_next = {rx_sh_reg[5:0], lanes_s[1:0]};
                MODE_QUAD:
                    rx_sh_next = {rx_sh_reg[3:0], lanes_s};
                default:
                    rx_sh_next = {rx_sh_reg[6:0], lanes_s[0]};
            endcase
            push_next = (cnt_reg == last_cnt);
            cnt_next  = (cnt_reg == last_cnt) ? CNT_INIT : cnt_reg + 3'h1;
        end
        else if (run && drive_in && clk_fall)                    // R5 R6
        begin
            unique case (eff_mode)
                MODE_DUAL:
                begin
                    out_next[1:0] = tx_src[7:6];
                    tx_sh_next    = {tx_src[5:0], 2'h0};
                end
                MODE_QUAD:
                begin
                    out_next   = tx_src[7:4];
                    tx_sh_next = {tx_src[3:0], 4'h0};
                end
                default:
                begin
                    out_next[1] = tx_src[7];
                    tx_sh_next  = {tx_src[6:0], 1'h0};
                end
            endcase
            cnt_next = (cnt_reg == last_cnt) ? CNT_INIT : cnt_reg + 3'h1;
        end
    end

    // One-byte holding register for read data from the user side
    always_comb
    begin
        tx_full_next = tx_full_reg;
        tx_hold_next = tx_hold_reg;
        if (hw_hold)
            tx_full_next = 1'h0;
        else if (tx_take)
            tx_full_next = 1'h0;
        else if (tx_valid_in && !tx_full_reg)
        begin
            tx_full_next = 1'h1;
            tx_hold_next = tx_data_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            cnt_reg     <= CNT_INIT;
            rx_sh_reg   <= BYTE_INIT;
            tx_sh_reg   <= BYTE_INIT;
            out_reg     <= LANE_OUT_INIT;
            push_reg    <= 1'h0;
            tx_full_reg <= 1'h0;
            tx_hold_reg <= BYTE_INIT;
        end
        else
        begin
            cnt_reg     <= cnt_next;
            rx_sh_reg   <= rx_sh_next;
            tx_sh_reg   <= tx_sh_next;
            out_reg     <= out_next;
            push_reg    <= push_next;
            tx_full_reg <= tx_full_next;
            tx_hold_reg <= tx_hold_next;
        end
    end

    assign tx_ready_out = !tx_full_reg;
    // Host clock cannot be stalled, so a full FIFO loses the byte
    assign rx_overrun_out = push_reg && !fifo_in_ready;

    // ----------------------------------------------------------------
    // Receive FIFO
    // ----------------------------------------------------------------
    sfpi_fifo #(
        .WIDTH (BYTE_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_in    (sys_clk_in),
        .reset_n_in    (reset_n_in),
        .flush_in      (hw_hold),
        .in_valid_in   (push_reg),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (rx_sh_reg),
        .out_valid_out (rx_valid_out),
        .out_ready_in  (rx_ready_in),
        .out_data_out  (rx_data_out)
    );

    // ----------------------------------------------------------------
    // Lane drivers
    // ----------------------------------------------------------------
    logic [3:0] lane_oe;

    // Drive only while selected, running a read and not paused
    assign lane_oe = (state_reg == ST_ACTIVE && drive_in && !pause_low) ?
                     lane_use : 4'h0;                            // R1 R12 R15

    assign data_lane_0_out    = out_reg[0];
    assign data_lane_1_out    = out_reg[1];
    assign data_lane_2_out    = out_reg[2];
    assign data_lane_3_out    = out_reg[3];
    assign data_lane_0_oe_out = lane_oe[0];
    assign data_lane_1_oe_out = lane_oe[1];
    assign data_lane_2_oe_out = lane_oe[2];
    assign data_lane_3_oe_out = lane_oe[3];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_pause_req;
        (state_reg == ST_ACTIVE) && !cs_s && pause_low && !hw_hold;
    endsequence

    sequence s_reset_pulse;
        hwrst_s ##1 !hwrst_s [*8] ##1 !hwrst_s [*2];
    endsequence

    a_deselect_float: assert property ( // R1
        cs_s |=> (lane_oe == 4'h0))
        else $error("lanes driven while deselected");

    a_select_enter: assert property ( // R2
        (state_reg == ST_DESELECTED) && !cs_s && !hw_hold
        |=> (state_reg == ST_ACTIVE))
        else $error("select did not activate");

    a_rx_rise_only: assert property ( // R4
        (cnt_reg != $past(cnt_reg)) && !$past(drive_in) && !$past(cs_s)
        && !$past(hw_hold) |-> $past(clk_rise))
        else $error("capture away from rising clock");

    a_tx_fall_only: assert property ( // R5
        (out_reg != $past(out_reg)) |-> $past(clk_fall))
        else $error("launch away from falling clock");

    a_quad_gate: assert property ( // R7
        !quad_enable_bit_in |-> (eff_mode != MODE_QUAD))
        else $error("quad used without enable bit");

    a_pin_reuse: assert property ( // R8
        quad_enable_bit_in |-> write_protect_n_out && !pause_low)
        else $error("protect or pause active in quad");

    a_lane_limit: assert property ( // R9
        (eff_mode != MODE_QUAD) |-> (lane_oe[3:2] == 2'h0))
        else $error("upper lanes driven outside quad");

    a_pause_float: assert property ( // R12
        s_pause_req |=> (state_reg == ST_PAUSED) && (lane_oe == 4'h0))
        else $error("pause did not float lanes");

    a_reset_abort: assert property ( // R13
        s_reset_pulse |=> hw_hold ##1 (state_reg == ST_WAIT_HIGH)
        && !rx_valid_out && tx_ready_out)
        else $error("reset pulse did not abort");

endmodule

// >>> sfpi_pkg.sv
// Constants and types shared by the serial flash pin interface
package sfpi_pkg;

    // --------
    // Lane modes and link states
    // --------
    typedef enum logic [1:0] {
        MODE_SINGLE,
        MODE_DUAL,
        MODE_QUAD
    } sfpi_mode_type;

    typedef enum logic [1:0] {
        ST_WAIT_HIGH,
        ST_DESELECTED,
        ST_ACTIVE,
        ST_PAUSED
    } sfpi_state_type;

    // --------
    // Timing
    // --------
    localparam int SYS_CLK_PERIOD_NS = 100;
    localparam int RESET_MIN_NS      = 1000;
    // Least time, so round up to whole cycles
    localparam int RESET_CYCLES      =
        (RESET_MIN_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam logic [3:0] RESET_CNT_MAX  = 4'(RESET_CYCLES);
    localparam logic [3:0] RESET_CNT_INIT = 4'h0;

    // --------
    // Data path
    // --------
    localparam int BYTE_BITS   = 8;
    localparam int FIFO_DEPTH  = 8;
    localparam int SYNC_WIDTH  = 7;
    localparam logic [2:0] CNT_INIT        = 3'h0;
    localparam logic [2:0] LAST_CNT_SINGLE = 3'h7;
    localparam logic [2:0] LAST_CNT_DUAL   = 3'h3;
    localparam logic [2:0] LAST_CNT_QUAD   = 3'h1;
    localparam logic [7:0] TX_IDLE_BYTE    = 8'hff;
    localparam logic [7:0] BYTE_INIT       = 8'h00;
    localparam logic [3:0] LANE_OUT_INIT   = 4'h0;
    localparam logic [3:0] LANES_SINGLE    = 4'h2;
    localparam logic [3:0] LANES_DUAL      = 4'h3;
    localparam logic [3:0] LANES_QUAD      = 4'hf;

endpackage

// >>> sfpi_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sfpi_sync
    import sfpi_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             sys_clk_in,
    input  wire logic             reset_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // --------
    // Stages
    // --------
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] stable_reg;

    // First stage is read only by the second
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            meta_reg   <= '0;
            stable_reg <= '0;
        end
        else
        begin
            meta_reg   <= async_in;
            stable_reg <= meta_reg;
        end
    end

    assign sync_out = stable_reg;

endmodule

// >>> sfpi_fifo.sv
// Receive byte FIFO with valid and ready on both sides
`timescale 1ns/1ps
module sfpi_fifo
    import sfpi_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    input  wire logic             sys_clk_in,
    input  wire logic             reset_n_in,
    input  wire logic             flush_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);

    // --------
    // Storage and pointers
    // --------
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      wr_ptr_next;
    logic [AW:0]      rd_ptr_reg;
    logic [AW:0]      rd_ptr_next;
    logic             full;
    logic             empty;
    logic             do_wr;
    logic             do_rd;

    // Extra pointer bit tells full from empty
    assign empty         = (wr_ptr_reg == rd_ptr_reg);
    assign full          = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                           (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    assign in_ready_out  = !full;
    assign out_valid_out = !empty;
    assign out_data_out  = mem_reg[rd_ptr_reg[AW-1:0]];
    assign do_wr         = in_valid_in && !full && !flush_in;
    assign do_rd         = out_ready_in && !empty && !flush_in;

    // Pointer next values
    always_comb
    begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        if (flush_in)
        begin
            wr_ptr_next = '0;
            rd_ptr_next = '0;
        end
        else
        begin
            if (do_wr)
                wr_ptr_next = wr_ptr_reg + (AW+1)'(1);
            if (do_rd)
                rd_ptr_next = rd_ptr_reg + (AW+1)'(1);
        end
    end

    // Pointer registers
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
        end
    end

    // Memory write; contents need no reset
    always_ff @(posedge sys_clk_in)
    begin
        if (do_wr)
            mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_in;
    end

endmodule

// >>> sfpi_host_model.sv
// Host-side serial master model: select, link clock and data lanes
`timescale 1ns/1ps
module sfpi_host_model
(
    input  wire logic       sys_clk_in,
    input  wire logic       quad_in,
    input  wire logic       hold_n_in,
    input  wire logic [3:0] lane_in,
    output logic            cs_n_out,
    output logic            sclk_out,
    output logic      [3:0] lane_out,
    output logic      [3:0] lane_oe_out
);
    logic [3:0] d_reg = 4'h0;
    logic [3:0] e_reg = 4'h0;

    // --------
    // Pins
    // --------
    // Clock idles high (mode 3), so each bit opens with a fall
    initial
    begin
        cs_n_out = 1'h1;
        sclk_out = 1'h1;
    end

    // Outside quad the host holds the protect pin high and drives the pause pin from hold_n_in
    assign lane_oe_out = quad_in ? e_reg : {2'h3, e_reg[1:0]};
    assign lane_out = quad_in ? d_reg : {hold_n_in, 1'h1, d_reg[1:0]};

    // --------
    // Transfers
    // --------
    // Select edge; the clock stands still while this runs
    task automatic frame(input logic sel_n);
        @(negedge sys_clk_in);
        e_reg = 4'h0;
        cs_n_out = sel_n;
        repeat (6) @(negedge sys_clk_in);
    endtask

    // n clocks of w lanes, MSB first; a read releases the host drivers
    task automatic shift(input int w, input int n, input logic [7:0] wb,
                         input logic rd, output logic [7:0] rb);
        logic [7:0] t;
        logic [3:0] m;
        t = wb;
        m = 4'((1 << w) - 1);
        rb = 8'h00;
        for (int i = 0; i < n; i++)
        begin
            sclk_out = 1'h0;
            e_reg = rd ? 4'h0 : m;
            d_reg = 4'(t[7:4] >> (4 - w));
            t = 8'(t << w);
            repeat (4) @(negedge sys_clk_in);
            sclk_out = 1'h1;
            repeat (3) @(negedge sys_clk_in);
            rb = 8'((rb << w) | (w == 1 ? {3'h0, lane_in[1]} : lane_in & m));
            @(negedge sys_clk_in);
        end
    endtask
endmodule

// >>> tb_top.sv
// Self-checking bench for the serial flash pin interface
`timescale 1ns/1ps
module tb_top
    import sfpi_pkg::*;
;
    logic          sys_clk_in = 1'h0;
    logic          flt_reg    = 1'h0;
    logic          ovr_seen   = 1'h0;
    logic          reset_n_in, hw_rst_n, qe, drive, tx_valid, rx_ready;
    logic          hold_n, cs_n, sclk, tx_ready, rx_valid, rx_ovr, sel;
    logic          paused, wp_n, drst;
    sfpi_mode_type mode;
    logic [7:0]    tx_data, rx_data, rb;
    logic [3:0]    h_out, h_oe, d_out, d_oe, lvl;
    int            error_cnt, checked;

    // --------
    // Clock, floating lanes and pulse catcher
    // --------
    always #50 sys_clk_in = ~sys_clk_in;

    // Undriven lanes toggle so a stale value can never pass as data
    always @(posedge sys_clk_in)
    begin
        flt_reg <= ~flt_reg;
        if (rx_ovr)
            ovr_seen <= 1'h1;
    end

    assign lvl = (d_oe & d_out) | (~d_oe & h_oe & h_out) |
                 (~d_oe & ~h_oe & {4{flt_reg}});

    sfpi_host_model host (.sys_clk_in(sys_clk_in), .quad_in(qe),
        .hold_n_in(hold_n), .lane_in(lvl), .cs_n_out(cs_n), .sclk_out(sclk),
        .lane_out(h_out), .lane_oe_out(h_oe));

    sfpi_core DUT (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .chip_select_n_in(cs_n), .serial_clock_in(sclk),
        .hardware_reset_n_in(hw_rst_n),
        .data_lane_0_in(lvl[0]), .data_lane_0_out(d_out[0]),
        .data_lane_0_oe_out(d_oe[0]), .data_lane_1_in(lvl[1]),
        .data_lane_1_out(d_out[1]), .data_lane_1_oe_out(d_oe[1]),
        .data_lane_2_in(lvl[2]), .data_lane_2_out(d_out[2]),
        .data_lane_2_oe_out(d_oe[2]), .data_lane_3_in(lvl[3]),
        .data_lane_3_out(d_out[3]), .data_lane_3_oe_out(d_oe[3]),
        .quad_enable_bit_in(qe), .lane_mode_in(mode), .drive_in(drive),
        .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .tx_data_in(tx_data),
        .rx_valid_out(rx_valid), .rx_ready_in(rx_ready), .rx_data_out(rx_data),
        .rx_overrun_out(rx_ovr), .selected_out(sel), .paused_out(paused),
        .write_protect_n_out(wp_n), .device_reset_out(drst));

    // --------
    // Shared tasks
    // --------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        if (error_cnt == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Bounded wait for a captured byte, compare it, then pop it
    task automatic take(input logic [7:0] exp);
        for (int i = 0; i < 40 && rx_valid !== 1'h1; i++)
            @(negedge sys_clk_in);
        check(rx_valid, 1'h1);
        check(rx_data, exp);
        rx_ready = 1'h1;
        @(negedge sys_clk_in);
        rx_ready = 1'h0;
    endtask

    // --------
    // Scenarios
    // --------
    // Whole bytes in every mode; the last is quad without enable
    task automatic t_write();
        for (int k = 0; k < 4; k++)
        begin
            mode = sfpi_mode_type'(k == 3 ? 2 : k);
            qe = (k == 2);
            host.frame(1'h0);
            host.shift(k == 3 ? 1 : 1 << k, k == 3 ? 8 : 8 >> k,
                       8'h39 ^ 8'(k), 1'h0, rb);
            check(wp_n, qe ? 1'h1 : lvl[2]);
            take(8'h39 ^ 8'(k));
            host.frame(1'h1);
        end
    endtask

    // Reads offered by the user side, launched on clock falls
    task automatic t_read();
        for (int k = 0; k < 3; k++)
        begin
            mode = sfpi_mode_type'(k);
            qe = (k == 2);
            drive = 1'h1;
            check(tx_ready, 1'h1);
            tx_valid = 1'h1;
            tx_data = 8'ha6 ^ 8'(k);
            @(negedge sys_clk_in);
            tx_valid = 1'h0;
            host.frame(1'h0);
            host.shift(1 << k, 8 >> k, 8'h00, 1'h1, rb);
            check(rb, 8'ha6 ^ 8'(k));
            check(d_oe, k == 0 ? 4'h2 : k == 1 ? 4'h3 : 4'hf);
            host.frame(1'h1);
            check(d_oe, 4'h0);
            drive = 1'h0;
        end
    endtask

    // Pause mid-byte: lanes float, clocks ignored, byte completes later
    task automatic t_pause();
        mode = MODE_SINGLE;
        qe = 1'h0;
        host.frame(1'h0);
        host.shift(1, 4, 8'h96, 1'h0, rb);
        hold_n = 1'h0;
        drive = 1'h1;
        repeat (5) @(negedge sys_clk_in);
        check(paused, 1'h1);
        check(d_oe, 4'h0);
        drive = 1'h0;
        host.shift(1, 4, 8'h00, 1'h0, rb);
        check(rx_valid, 1'h0);
        hold_n = 1'h1;
        repeat (5) @(negedge sys_clk_in);
        check(paused, 1'h0);
        host.shift(1, 4, 8'h60, 1'h0, rb);
        take(8'h96);
        host.frame(1'h1);
    endtask

    // Reset pin: a short glitch is filtered, a long pulse aborts
    task automatic t_hwrst();
        host.frame(1'h0);
        host.shift(1, 4, 8'h5a, 1'h0, rb);
        hw_rst_n = 1'h0;
        repeat (5) @(negedge sys_clk_in);
        hw_rst_n = 1'h1;
        repeat (5) @(negedge sys_clk_in);
        check(drst, 1'h0);
        hw_rst_n = 1'h0;
        repeat (14) @(negedge sys_clk_in);
        check(drst, 1'h1);
        check(sel, 1'h0);
        hw_rst_n = 1'h1;
        repeat (5) @(negedge sys_clk_in);
        host.shift(1, 4, 8'h5a, 1'h0, rb);
        check(rx_valid, 1'h0);
        host.frame(1'h1);
        host.frame(1'h0);
        host.shift(1, 8, 8'hc3, 1'h0, rb);
        take(8'hc3);
        host.frame(1'h1);
    endtask

    // Overfill the receive FIFO with the reader stalled, then drain it
    task automatic t_fifo();
        host.frame(1'h0);
        for (int i = 0; i < 9; i++)
            host.shift(1, 8, 8'h10 + 8'(i), 1'h0, rb);
        repeat (6) @(negedge sys_clk_in);
        check(ovr_seen, 1'h1);
        for (int i = 0; i < 8; i++)
            take(8'h10 + 8'(i));
        check(rx_valid, 1'h0);
        host.frame(1'h1);
    endtask

    // --------
    // Main sequence and watchdog
    // --------
    initial
    begin
        {reset_n_in, hw_rst_n, qe, drive, tx_valid, rx_ready, hold_n} = 7'h21;
        mode = MODE_SINGLE;
        tx_data = 8'h00;
        repeat (20) @(negedge sys_clk_in);
        reset_n_in = 1'h1;
        repeat (5) @(negedge sys_clk_in);
        check(sel, 1'h0);
        check(d_oe, 4'h0);
        t_write();
        t_read();
        t_pause();
        t_hwrst();
        t_fifo();
        end_of_test();
    end

    // The run takes well under two thousand cycles; this leaves wide margin
    initial
    begin
        repeat (20000) @(posedge sys_clk_in);
        error_cnt++;
        end_of_test();
    end
endmodule
